/* common/tio_pkg.sv */
// Behaviour
// - There are four independent TTL inputs, two TTL outputs and two relay outputs, each controlled on its own.
// - Each TTL input is assigned either to schedule start/resume or to sample temperature control.
// - Each input has four control types (normal edge, inverted edge, normal pulse, inverted pulse), normal edge after reset.
// - In normal edge mode a falling transition activates the assigned function.
// - Start/resume starts the schedule when it is not running and resumes it when it is on hold.
// - In edge modes the deactivating transition does nothing to an input assigned to start/resume.
// - In edge modes, for temperature control, the activating transition switches it on and the other one off.
// - Inverted edge mode is normal edge mode with rising and falling transitions swapped.
// - In normal pulse mode only the falling transition is active and the rising one is ignored.
// - In pulse modes an active pulse of at least 50 ms is always detected, so the driver must send at least that.
// - In pulse modes pulses of 4 ms or less are ignored; widths in between may go either way.
// - Inverted pulse mode is normal pulse mode with the active and ignored transitions swapped.
// - Each relay is open while its state is off and closed only while its state is on.
// - Each TTL output idles high and is driven low for the on state.
// - Writing 1 to an output state turns that output on and writing 0 turns it off.
package tio_pkg;

  localparam int N_IN = 4;
  localparam int N_TTL = 2;
  localparam int N_RLY = 2;

  // timebase
  localparam int CLK_HZ = 20_000_000;
  localparam int MS_PER_S = 1000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYC_DEF = CLK_HZ / MS_PER_S * TICK_MS;
  localparam int PULSE_SURE_MS = 50;
  localparam int PULSE_IGN_MS = 4;
  // one tick more than the ignore limit: tick phase is unknown at pulse start
  localparam int QUAL_TICKS = PULSE_IGN_MS / TICK_MS + 1;
  localparam int QCNT_W = 3;

  // register map, byte addresses
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFF_CFG = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_OUT = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_STAT = 4'h8;
  localparam logic [ADDR_W-1:0] OFF_EVT = 4'hC;
  localparam int DATA_W = 32;
  localparam int EVT_W = 8;

  typedef enum logic [1:0] {TIO_NEDGE, TIO_IEDGE, TIO_NPULSE, TIO_IPULSE} tio_mode_t;
  typedef enum logic {TIO_FN_SCHED, TIO_FN_TEMP} tio_fn_t;

  typedef struct packed {
    tio_fn_t fn;
    tio_mode_t mode;
  } tio_cfg_t;

  localparam int CFG_W = $bits(tio_cfg_t);
  localparam int CFG_REG_W = CFG_W * N_IN;
  localparam logic [CFG_REG_W-1:0] CFG_RST = 12'h000;

  typedef struct packed {
    logic [N_RLY-1:0] rly;
    logic [N_TTL-1:0] ttl;
  } tio_out_t;

  localparam int OUT_W = $bits(tio_out_t);
  localparam logic [OUT_W-1:0] OUT_RST = 4'h0;

  typedef struct packed {
    logic hold;
    logic run;
    logic temp;
    logic [N_IN-1:0] lvl;
  } tio_stat_t;

  typedef struct packed {
    logic act;
    logic deact;
  } tio_evt_t;

  typedef enum logic [1:0] {TIO_ST_IDLE, TIO_ST_QUAL, TIO_ST_HELD} tio_qst_t;

endpackage

/* hdl/tio_inchan.sv */
`timescale 1ns/1ns
module tio_inchan (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pin and timebase
  input wire logic pin,
  input wire logic tick,
  // channel setup
  input tio_pkg::tio_cfg_t cfg,
  // results
  output tio_pkg::tio_evt_t evt,
  output logic lvl
);
  import tio_pkg::*;

  logic sync1_ff, sync2_ff, prev_ff;
  tio_qst_t state_ff, nxt_state;
  logic [QCNT_W-1:0] qcnt_ff, nxt_qcnt;
  tio_evt_t evt_ff, nxt_evt;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_ff <= 1'h1;
      sync2_ff <= 1'h1;
      prev_ff <= 1'h1;
    end else begin
      sync1_ff <= pin;
      sync2_ff <= sync1_ff;
      prev_ff <= sync2_ff;
    end
  end

  // a mode change alone gives no edge, as act_lvl and prev_act share the mode; software should reconfigure while idle
  wire inv = (cfg.mode == TIO_IEDGE) || (cfg.mode == TIO_IPULSE);
  wire pulse_md = (cfg.mode == TIO_NPULSE) || (cfg.mode == TIO_IPULSE);
  wire act_lvl = inv ? sync2_ff : ~sync2_ff;
  wire prev_act = inv ? prev_ff : ~prev_ff;
  wire act_edge = act_lvl & ~prev_act;
  wire deact_edge = ~act_lvl & prev_act;
  wire q_last = (qcnt_ff == QCNT_W'(QUAL_TICKS - 1));
  wire q_fire = (state_ff == TIO_ST_QUAL) & act_lvl & tick & q_last;

  always_comb begin
    nxt_state = state_ff;
    nxt_qcnt = qcnt_ff;
    case (state_ff)
      TIO_ST_IDLE: begin
        if (pulse_md && act_edge) begin
          nxt_state = TIO_ST_QUAL;
          nxt_qcnt = '0;
        end
      end
      TIO_ST_QUAL: begin
        if (!act_lvl || !pulse_md) begin
          nxt_state = TIO_ST_IDLE;
        end else if (tick) begin
          if (q_last) begin
            nxt_state = TIO_ST_HELD;
          end else begin
            nxt_qcnt = qcnt_ff + QCNT_W'(1);
          end
        end
      end
      TIO_ST_HELD: begin
        if (!act_lvl || !pulse_md) begin
          nxt_state = TIO_ST_IDLE;
        end
      end
      default: nxt_state = TIO_ST_IDLE;
    endcase
    nxt_evt.act = pulse_md ? q_fire : act_edge;
    nxt_evt.deact = ~pulse_md & deact_edge;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= TIO_ST_IDLE;
      qcnt_ff <= '0;
      evt_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      qcnt_ff <= nxt_qcnt;
      evt_ff <= nxt_evt;
    end
  end

  assign evt = evt_ff;
  assign lvl = sync2_ff;

  // helper: ticks seen while the pulse is active
  logic [QCNT_W:0] htick_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      htick_ff <= '0;
    end else if (!act_lvl) begin
      htick_ff <= '0;
    end else if (tick && htick_ff != '1) begin
      htick_ff <= htick_ff + (QCNT_W + 1)'(1);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  pulse_width_a: assert property (q_fire |-> htick_ff >= (QCNT_W + 1)'(QUAL_TICKS - 1))
    else $error("pulse accepted before qualifying ticks");
  edge_strobe_a: assert property (!pulse_md && act_edge |=> evt_ff.act ##1 !evt_ff.act)
    else $error("edge mode activation not one strobe");
  pulse_noend_a: assert property (pulse_md && $stable(cfg) |=> !evt_ff.deact)
    else $error("pulse mode produced a deactivation");
  sync_delay_a: assert property (lvl == $past(pin, 2))
    else $error("input not delayed two stages");
  pulse_cov_c: cover property (pulse_md && q_fire);
endmodule // tio_inchan

/* hdl/tio_top.sv */
// Our own choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ns
module tio_top #(
  parameter int TICK_CYC = tio_pkg::TICK_CYC_DEF
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // avalon-mm slave
  input wire logic [tio_pkg::ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [tio_pkg::DATA_W-1:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [tio_pkg::DATA_W-1:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // ttl inputs from the controlling instrument
  input wire logic [tio_pkg::N_IN-1:0] TTL_IN,
  // schedule engine
  input wire logic SCHED_RUNNING,
  input wire logic SCHED_HOLD,
  output logic SCHED_START,
  output logic SCHED_RESUME,
  // sample temperature control
  output logic TEMP_ON,
  output logic TEMP_OFF,
  output logic TEMP_CTRL,
  // outputs to external equipment
  output logic [tio_pkg::N_TTL-1:0] TTL_OUT_N,
  output logic [tio_pkg::N_RLY-1:0] RELAY_CLOSE
);
  import tio_pkg::*;

  localparam int TCNT_W = $clog2(TICK_CYC);

  // reset release through two flops
  logic [1:0] rst_sync_ff;
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'h1};
    end
  end
  wire rst_n = rst_sync_ff[1];

  // millisecond tick
  logic [TCNT_W-1:0] tcnt_ff, nxt_tcnt;
  logic tick_ff;
  wire tc_end = (tcnt_ff == TCNT_W'(TICK_CYC - 1));
  assign nxt_tcnt = tc_end ? '0 : tcnt_ff + TCNT_W'(1);

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      tcnt_ff <= '0;
      tick_ff <= 1'h0;
    end else begin
      tcnt_ff <= nxt_tcnt;
      tick_ff <= tc_end;
    end
  end

  // register file
  logic [CFG_REG_W-1:0] cfg_ff, nxt_cfg;
  tio_out_t out_ff, nxt_out;
  logic [EVT_W-1:0] evt_cnt_ff, nxt_evt_cnt;
  logic waitreq_ff, nxt_waitreq;
  logic [DATA_W-1:0] rdata_ff, nxt_rdata;
  logic temp_ff, nxt_temp;

  // one wait state: take on the first edge, answer on the next
  wire req = AVS_READ | AVS_WRITE;
  wire take = req & waitreq_ff;
  wire commit = AVS_WRITE & ~waitreq_ff;
  wire sel_cfg = (AVS_ADDRESS == OFF_CFG);
  wire sel_out = (AVS_ADDRESS == OFF_OUT);
  wire sel_stat = (AVS_ADDRESS == OFF_STAT);
  wire sel_evt = (AVS_ADDRESS == OFF_EVT);

  wire [DATA_W-1:0] be_mask = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
                               {8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
  wire [DATA_W-1:0] cfg_word = DATA_W'(cfg_ff);
  wire [DATA_W-1:0] out_word = DATA_W'(out_ff);
  wire [DATA_W-1:0] evt_word = DATA_W'(evt_cnt_ff);
  tio_stat_t stat;
  assign stat.hold = SCHED_HOLD;
  assign stat.run = SCHED_RUNNING;
  assign stat.temp = temp_ff;
  wire [DATA_W-1:0] stat_word = DATA_W'(stat);

  wire [DATA_W-1:0] cfg_merge = (cfg_word & ~be_mask) | (AVS_WRITEDATA & be_mask);
  wire [DATA_W-1:0] out_merge = (out_word & ~be_mask) | (AVS_WRITEDATA & be_mask);

  assign nxt_cfg = (commit && sel_cfg) ? cfg_merge[CFG_REG_W-1:0] : cfg_ff;
  assign nxt_out = (commit && sel_out) ? tio_out_t'(out_merge[OUT_W-1:0]) : out_ff;
  assign nxt_waitreq = ~take;
  // unmapped addresses read as zero and ignore writes
  assign nxt_rdata = !take ? rdata_ff :
                     sel_cfg ? cfg_word :
                     sel_out ? out_word :
                     sel_stat ? stat_word :
                     sel_evt ? evt_word : 32'h0000_0000;

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      cfg_ff <= CFG_RST;
      out_ff <= OUT_RST;
      waitreq_ff <= 1'h1;
      rdata_ff <= 32'h0000_0000;
    end else begin
      cfg_ff <= nxt_cfg;
      out_ff <= nxt_out;
      waitreq_ff <= nxt_waitreq;
      rdata_ff <= nxt_rdata;
    end
  end

  // input channels
  tio_cfg_t ch_cfg [N_IN];
  tio_evt_t ch_evt [N_IN];
  logic [N_IN-1:0] ch_lvl;
  logic [N_IN-1:0] act_sched, temp_on_e, temp_off_e, temp_tgl;

  for (genvar i = 0; i < N_IN; i++) begin : g_ch
    wire is_pulse = (ch_cfg[i].mode == TIO_NPULSE) || (ch_cfg[i].mode == TIO_IPULSE);
    wire is_temp = (ch_cfg[i].fn == TIO_FN_TEMP);
    assign ch_cfg[i] = tio_cfg_t'(cfg_ff[i*CFG_W +: CFG_W]);
    assign act_sched[i] = ch_evt[i].act & ~is_temp;
    assign temp_on_e[i] = ch_evt[i].act & is_temp & ~is_pulse;
    assign temp_off_e[i] = ch_evt[i].deact & is_temp & ~is_pulse;
    assign temp_tgl[i] = ch_evt[i].act & is_temp & is_pulse;
    tio_inchan u_ch (
      .clk(MCLK),
      .rst_n(rst_n),
      .pin(TTL_IN[i]),
      .tick(tick_ff),
      .cfg(ch_cfg[i]),
      .evt(ch_evt[i]),
      .lvl(ch_lvl[i])
    );
  end
  assign stat.lvl = ch_lvl;

  // function decode
  wire start_req = |act_sched;
  wire temp_on_req = |temp_on_e;
  wire temp_off_req = |temp_off_e;
  wire temp_tgl_req = |temp_tgl;
  // pulse mode has no off edge, so a pulse toggles; on beats off when both land together
  assign nxt_temp = temp_on_req ? 1'h1 :
                    temp_off_req ? 1'h0 :
                    temp_tgl_req ? ~temp_ff : temp_ff;
  wire nxt_start = start_req & ~SCHED_RUNNING;
  wire nxt_resume = start_req & SCHED_RUNNING & SCHED_HOLD;
  wire any_evt = start_req | temp_on_req | temp_off_req | temp_tgl_req;
  wire evt_clr = commit & sel_evt;
  // a clear in the same cycle as an event keeps that event
  assign nxt_evt_cnt = (evt_clr ? EVT_W'(0) : evt_cnt_ff) + EVT_W'(any_evt);

  logic sched_start_ff, sched_resume_ff, temp_on_ff, temp_off_ff;
  logic [N_TTL-1:0] ttl_n_ff;
  logic [N_RLY-1:0] rly_ff;

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      temp_ff <= 1'h0;
      evt_cnt_ff <= '0;
      sched_start_ff <= 1'h0;
      sched_resume_ff <= 1'h0;
      temp_on_ff <= 1'h0;
      temp_off_ff <= 1'h0;
    end else begin
      temp_ff <= nxt_temp;
      evt_cnt_ff <= nxt_evt_cnt;
      sched_start_ff <= nxt_start;
      sched_resume_ff <= nxt_resume;
      temp_on_ff <= nxt_temp & ~temp_ff;
      temp_off_ff <= ~nxt_temp & temp_ff;
    end
  end

  // output pins follow the state one cycle later
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      ttl_n_ff <= '1;
      rly_ff <= '0;
    end else begin
      ttl_n_ff <= ~out_ff.ttl;
      rly_ff <= out_ff.rly;
    end
  end

  assign AVS_READDATA = rdata_ff;
  assign AVS_WAITREQUEST = waitreq_ff;
  assign SCHED_START = sched_start_ff;
  assign SCHED_RESUME = sched_resume_ff;
  assign TEMP_ON = temp_on_ff;
  assign TEMP_OFF = temp_off_ff;
  assign TEMP_CTRL = temp_ff;
  assign TTL_OUT_N = ttl_n_ff;
  assign RELAY_CLOSE = rly_ff;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!rst_n);

  bus_answer_a: assert property (req && AVS_WAITREQUEST |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
    else $error("bus answer not after one wait state");
  out_write_a: assert property (commit && sel_out && AVS_BYTEENABLE[0]
      |=> ##1 RELAY_CLOSE == $past(AVS_WRITEDATA[OUT_W-1:N_TTL], 2))
    else $error("relay does not follow written state");
  ttl_level_a: assert property (##1 TTL_OUT_N == ~$past(out_ff.ttl))
    else $error("ttl output not inverted state");
  start_gate_a: assert property (start_req && !SCHED_RUNNING |=> SCHED_START && !SCHED_RESUME)
    else $error("start not issued when schedule idle");
  resume_gate_a: assert property (start_req && SCHED_RUNNING && SCHED_HOLD |=> SCHED_RESUME && !SCHED_START)
    else $error("resume not issued on hold");
  no_start_a: assert property (!start_req |=> !SCHED_START && !SCHED_RESUME)
    else $error("schedule strobe without activation");
  temp_onoff_a: assert property (temp_on_req |=> TEMP_CTRL ##0 (TEMP_ON == !$past(TEMP_CTRL)))
    else $error("temperature control not switched on");
  temp_off_a: assert property (temp_off_req && !temp_on_req |=> !TEMP_CTRL)
    else $error("temperature control not switched off");
  strobe_one_a: assert property (TEMP_ON |=> !TEMP_ON)
    else $error("temperature strobe longer than one cycle");
  reset_mode_a: assert property ($rose(rst_n) |-> cfg_ff == CFG_RST)
    else $error("channels not normal edge after reset");

  start_cov_c: cover property (SCHED_START);
  resume_cov_c: cover property (SCHED_RESUME);
  temp_off_cov_c: cover property (TEMP_OFF);
  relay_cov_c: cover property (RELAY_CLOSE[0] && !TTL_OUT_N[1]);
endmodule // tio_top

/* verif/tio_ctl_model.sv */
`timescale 1ns/1ns
// controlling instrument: drives the four ttl lines, pulled up when idle
module tio_ctl_model (
  // clock
  input wire logic mclk,
  // ttl lines towards the device
  output logic [3:0] line
);
  initial line = 4'hF;

  // level change, launched just after an edge
  task automatic drive(input int ch, input logic v);
    @(posedge mclk);
    line[ch] <= v;
  endtask

  // pulse at level v; callers keep sure pulses at 50 ms or longer
  task automatic pulse(input int ch, input logic v, input int cyc);
    drive(ch, v);
    repeat (cyc) @(posedge mclk);
    line[ch] <= !v;
  endtask
endmodule // tio_ctl_model

/* verif/tio_top_tb.sv */
`timescale 1ns/1ns
module tio_top_tb;
  import tio_pkg::*;
  localparam int T = 20;
  logic MCLK, RST_N, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, SCHED_RUNNING, SCHED_HOLD;
  logic SCHED_START, SCHED_RESUME, TEMP_ON, TEMP_OFF, TEMP_CTRL;
  logic [ADDR_W-1:0] AVS_ADDRESS;
  logic [DATA_W-1:0] AVS_WRITEDATA, AVS_READDATA, q, rnd;
  logic [N_IN-1:0] TTL_IN, pin_m;
  logic [N_TTL-1:0] TTL_OUT_N;
  logic [N_RLY-1:0] RELAY_CLOSE;
  int bad_count, checks, cyc, n_start, n_res, n_on, n_off, temp_m, evt_m;
  int mode_m[4];
  int fn_m[4];

  tio_top #(.TICK_CYC(T)) i_tio_top (.MCLK(MCLK), .RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
    .AVS_BYTEENABLE(4'hF), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .TTL_IN(TTL_IN), .SCHED_RUNNING(SCHED_RUNNING), .SCHED_HOLD(SCHED_HOLD),
    .SCHED_START(SCHED_START), .SCHED_RESUME(SCHED_RESUME), .TEMP_ON(TEMP_ON),
    .TEMP_OFF(TEMP_OFF), .TEMP_CTRL(TEMP_CTRL), .TTL_OUT_N(TTL_OUT_N), .RELAY_CLOSE(RELAY_CLOSE));
  tio_ctl_model i_tio_ctl_model (.mclk(MCLK), .line(TTL_IN));

  initial begin
    MCLK = 1'b0;
    forever #25 MCLK = !MCLK;
  end

  // strobe cycles counted, so a stretched strobe shows as a count above one
  always @(posedge MCLK) begin
    n_start += (SCHED_START === 1'b1);
    n_res += (SCHED_RESUME === 1'b1);
    n_on += (TEMP_ON === 1'b1);
    n_off += (TEMP_OFF === 1'b1);
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      final_report();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // one avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge MCLK);
    AVS_ADDRESS <= a;
    AVS_WRITE <= wr;
    AVS_READ <= !wr;
    AVS_WRITEDATA <= d;
    // no local limit: only the cycle ceiling ends a hung transfer
    do begin
      @(posedge MCLK);
      n++;
    end while (AVS_WAITREQUEST !== 1'b0);
    q = AVS_READDATA;
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
    chk("wait_states", n, 32'h0000_0002);
  endtask

  task automatic set_cfg(input int ch, input int fn, input int md);
    logic [31:0] w;
    fn_m[ch] = fn;
    mode_m[ch] = md;
    w = 32'h0000_0000;
    for (int i = 0; i < 4; i++) w[3*i +: 3] = 3'(fn_m[i] * 4 + mode_m[i]);
    bus(1'b1, OFF_CFG, w);
    bus(1'b0, OFF_CFG, 32'h0000_0000);
    chk("cfg", q, w);
  endtask

  // len 0: level change to lvl; else pulse at lvl of len cycles
  task automatic fire(input int ch, input logic lvl, input int len);
    int es, er, eon, eoff;
    bit act, deact;
    es = 0;
    er = 0;
    eon = 0;
    eoff = 0;
    n_start = 0;
    n_res = 0;
    n_on = 0;
    n_off = 0;
    if (len == 0) begin
      i_tio_ctl_model.drive(ch, lvl);
      pin_m[ch] = lvl;
      act = (mode_m[ch] == 0) ? !lvl : (mode_m[ch] == 1) ? lvl : 1'b0;
      deact = mode_m[ch] < 2 && !act;
    end else begin
      i_tio_ctl_model.pulse(ch, lvl, len);
      act = len >= 50 * T;
      deact = 1'b0;
    end
    if (fn_m[ch] == 0 && act && !SCHED_RUNNING) es = 1;
    if (fn_m[ch] == 0 && act && SCHED_RUNNING && SCHED_HOLD) er = 1;
    if (act || (deact && fn_m[ch] == 1)) evt_m++;
    if (fn_m[ch] == 1) begin
      if (act && mode_m[ch] >= 2) begin
        if (temp_m) eoff = 1;
        else eon = 1;
        temp_m = !temp_m;
      end else if (act && !temp_m) begin
        eon = 1;
        temp_m = 1;
      end else if (deact && temp_m) begin
        eoff = 1;
        temp_m = 0;
      end
    end
    repeat (12) @(posedge MCLK);
    chk("sched_start", n_start, es);
    chk("sched_resume", n_res, er);
    chk("temp_on", n_on, eon);
    chk("temp_off", n_off, eoff);
    chk("temp_ctrl", TEMP_CTRL, temp_m[0]);
    bus(1'b0, OFF_STAT, 32'h0000_0000);
    chk("status", q, {25'h000_0000, SCHED_HOLD, SCHED_RUNNING, temp_m[0], pin_m});
  endtask

  task automatic sched(input logic run, input logic hold);
    @(posedge MCLK);
    SCHED_RUNNING <= run;
    SCHED_HOLD <= hold;
  endtask

  initial begin
    RST_N = 1'b0;
    AVS_READ = 1'b0;
    AVS_WRITE = 1'b0;
    AVS_ADDRESS = 4'h0;
    AVS_WRITEDATA = 32'h0000_0000;
    SCHED_RUNNING = 1'b0;
    SCHED_HOLD = 1'b0;
    pin_m = 4'hF;
    temp_m = 0;
    evt_m = 0;
    rnd = 32'h0000_7FFF;
    for (int i = 0; i < 4; i++) begin
      mode_m[i] = 0;
      fn_m[i] = 0;
    end
    repeat (16) @(posedge MCLK);
    RST_N <= 1'b1;
    repeat (4) @(posedge MCLK);
    chk("ttl_out_n", TTL_OUT_N, 2'b11);
    chk("relay", RELAY_CLOSE, 2'b00);
    chk("temp_ctrl", TEMP_CTRL, 1'b0);
    bus(1'b0, OFF_CFG, 32'h0000_0000);
    chk("cfg_rst", q, 32'h0000_0000);
    bus(1'b0, 4'h2, 32'h0000_0000);
    chk("unmapped", q, 32'h0000_0000);
    // random output states, each driven and read back
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      bus(1'b1, OFF_OUT, rnd);
      repeat (2) @(posedge MCLK);
      chk("ttl_out_n", TTL_OUT_N, 2'(~rnd[1:0]));
      chk("relay", RELAY_CLOSE, rnd[3:2]);
      bus(1'b0, OFF_OUT, 32'h0000_0000);
      chk("out_rd", q, {28'h000_0000, rnd[3:0]});
    end
    set_cfg(1, 1, 0);
    set_cfg(2, 1, 1);
    set_cfg(3, 0, 2);
    // schedule input in every schedule state, both transitions
    for (int s = 0; s < 3; s++) begin
      sched(s > 0, s == 1);
      fire(0, 1'b0, 0);
      fire(0, 1'b1, 0);
    end
    sched(1'b0, 1'b0);
    // temperature from two inputs of opposite sense
    fire(1, 1'b0, 0);
    fire(1, 1'b1, 0);
    fire(1, 1'b0, 0);
    fire(2, 1'b0, 0);
    fire(2, 1'b1, 0);
    fire(1, 1'b1, 0);
    fire(2, 1'b0, 0);
    // glitch at the ignore limit, then a sure pulse
    fire(3, 1'b0, 4 * T);
    fire(3, 1'b0, 50 * T);
    // line is low here, the idle level of the inverted pulse mode
    set_cfg(2, 1, 3);
    fire(2, 1'b1, 4 * T);
    fire(2, 1'b1, 50 * T);
    // event counter: every recognised function event, then a clear
    bus(1'b0, OFF_EVT, 32'h0000_0000);
    chk("evt_cnt", q, evt_m & 32'h0000_00FF);
    bus(1'b1, OFF_EVT, 32'h0000_0000);
    bus(1'b0, OFF_EVT, 32'h0000_0000);
    chk("evt_clr", q, 32'h0000_0000);
    final_report();
  end
endmodule // tio_top_tb
